// ==== hw/rsc_pkg.sv ====
// shared constants and types of the repeater setup chain loader
package rsc_pkg;
    // =========================================================
    // clocking and timing
    // =========================================================
    localparam int CLK_HZ = 50_000_000;     // system clock rate
    localparam int SCLK_HZ = 1_000_000;     // serial shift clock rate
    localparam int SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_HZ);
    localparam int RST_HOLD_MS = 1;         // least reset pin hold time
    localparam int RST_HOLD_CYC_DEF = (RST_HOLD_MS * CLK_HZ + 999) / 1000;
    // =========================================================
    // serial load format
    // =========================================================
    localparam int SETUP_BITS = 48;         // setup bits per device
    localparam int REQ_BITS = 9;            // request sequence length
    localparam logic [8:0] REQ_PATTERN = 9'h180; // start, read, addr 0
    // =========================================================
    // register map (byte offsets) and fields
    // =========================================================
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_SETUP_LO = 8'h08;
    localparam logic [7:0] ADDR_SETUP_HI = 8'h0c;
    localparam int CTRL_LOAD_EN = 0;        // ctrl: loader enable bit
    localparam int ST_DONE = 0;             // status bit positions
    localparam int ST_BUSY = 1;
    localparam int ST_LOCAL = 2;
    localparam int ST_FIRST = 3;
    localparam int ST_TEST = 4;
    localparam int ST_CORE_RST = 5;
    // =========================================================
    // synchronised pin vector positions
    // =========================================================
    localparam int PIN_MODE = 0;
    localparam int PIN_FIRST = 1;
    localparam int PIN_SQE = 2;
    localparam int PIN_TP = 3;              // four bits, 3..6
    localparam int PIN_AUX = 7;
    localparam int PIN_TEST = 8;
    localparam int PIN_CHIPRST = 9;
    localparam int PIN_W = 10;
    // link side phases
    typedef enum logic [1:0] {
        LP_IDLE = 2'b00,
        LP_REQ = 2'b01,
        LP_SHIFT = 2'b10,
        LP_DONE = 2'b11
    } rsc_lphase_t;
endpackage

// ==== hw/rsc_link_if.sv ====
// signals between the system side and the shift clock side
interface rsc_link_if;
    import rsc_pkg::*;
    logic run;                    // loader allowed to run, level
    logic first;                  // first position strap, level
    logic done;                   // all setup bits loaded
    logic active;                 // setup bits being shifted
    logic req_bit;                // request sequence bit
    logic [SETUP_BITS-1:0] bits;  // captured setup word
    modport sys (output run, output first, input done, input active,
                 input req_bit, input bits);
    modport lnk (input run, input first, output done, output active,
                 output req_bit, output bits);
endinterface

// ==== hw/rsc_sync.sv ====
// two flip-flop level synchroniser of parameter width
module rsc_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [W-1:0] s1;   // first stage, read only by s2
        logic [W-1:0] s2;   // stable stage
    } rsc_sync_t;
    rsc_sync_t r_ff;
    rsc_sync_t nxt_r;

    // next stage values
    always_comb begin
        nxt_r = r_ff;
        if (i_rst) begin
            nxt_r = '0;
        end else begin
            nxt_r.s1 = i_d;
            nxt_r.s2 = r_ff.s1;
        end
    end

    // registers
    always_ff @(posedge i_clk) begin
        r_ff <= nxt_r;
    end

    assign o_q = r_ff.s2;
endmodule

// ==== hw/rsc_link_shift.sv ====
// shift clock side: request sequence out, setup bits in
module rsc_link_shift
    import rsc_pkg::*;
(
    input wire logic i_setup_shift_clock,
    input wire logic i_chain_enable_in_n,
    input wire logic i_setup_bit_in,
    rsc_link_if.lnk lk
);
    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        rsc_lphase_t phase;          // load phase
        logic [3:0] req_cnt;         // request bits sent
        logic req_bit;               // request pin level
        logic [5:0] cnt;             // setup bits taken
        logic [SETUP_BITS-1:0] bits; // first bit ends in msb
        logic chain_enable_in_n_prev;             // enable input, last edge
        logic done;                  // glitch free done flag
        logic active;                // glitch free busy flag
    } rsc_link_t;
    rsc_link_t l_ff;
    rsc_link_t nxt_l;
    logic [1:0] ctl_s;   // synchronised run and first
    logic run_l;
    logic first_l;
    logic chain_enable_in_n_fall;

    // run and strap cross into this domain
    rsc_sync #(.W(2)) u_ctl_sync (
        .i_clk(i_setup_shift_clock),
        .i_rst(1'b0),
        .i_d({lk.first, lk.run}),
        .o_q(ctl_s)
    );
    assign run_l = ctl_s[0];
    assign first_l = ctl_s[1];
    assign chain_enable_in_n_fall = l_ff.chain_enable_in_n_prev & ~i_chain_enable_in_n;

    // =========================================================
    // load sequence
    // =========================================================
    always_comb begin
        nxt_l = l_ff;
        nxt_l.chain_enable_in_n_prev = i_chain_enable_in_n;
        if (!run_l) begin
            // held low enable is not a transition: prev starts low
            nxt_l.phase = LP_IDLE;
            nxt_l.req_cnt = 4'h0;
            nxt_l.req_bit = 1'b0;
            nxt_l.cnt = 6'h00;
            nxt_l.bits = '0;
            nxt_l.chain_enable_in_n_prev = 1'b0;
        end else begin
            unique case (l_ff.phase)
                LP_IDLE: begin
                    if (first_l) begin
                        nxt_l.req_bit = REQ_PATTERN[REQ_BITS-1];
                        nxt_l.req_cnt = 4'h1;
                        nxt_l.phase = LP_REQ;
                    end else if (chain_enable_in_n_fall) begin
                        nxt_l.bits = {l_ff.bits[SETUP_BITS-2:0],
                                      i_setup_bit_in};
                        nxt_l.cnt = 6'h01;
                        nxt_l.phase = LP_SHIFT;
                    end
                end
                LP_REQ: begin
                    if (l_ff.req_cnt < 4'(REQ_BITS)) begin
                        nxt_l.req_bit = REQ_PATTERN[4'(REQ_BITS-1) -
                                                    l_ff.req_cnt];
                        nxt_l.req_cnt = l_ff.req_cnt + 4'h1;
                    end else begin
                        nxt_l.req_bit = 1'b0;
                        nxt_l.phase = LP_SHIFT;
                    end
                end
                LP_SHIFT: begin
                    nxt_l.bits = {l_ff.bits[SETUP_BITS-2:0],
                                  i_setup_bit_in};
                    nxt_l.cnt = l_ff.cnt + 6'h01;
                    if (l_ff.cnt == 6'(SETUP_BITS-1)) begin
                        nxt_l.phase = LP_DONE;
                    end
                end
                LP_DONE: begin
                    nxt_l.phase = LP_DONE;
                end
            endcase
        end
        nxt_l.done = (nxt_l.phase == LP_DONE);
        nxt_l.active = (nxt_l.phase == LP_SHIFT);
    end

    // registers on the shared shift clock rising edge
    always_ff @(posedge i_setup_shift_clock) begin
        l_ff <= nxt_l;
    end

    assign lk.done = l_ff.done;
    assign lk.active = l_ff.active;
    assign lk.req_bit = l_ff.req_bit;
    assign lk.bits = l_ff.bits;

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge i_setup_shift_clock);
    endclocking
    default disable iff (!run_l);

    sequence s_last_bit;
        l_ff.active && l_ff.cnt == 6'(SETUP_BITS-1);
    endsequence
    AST_DONE_AT_48: assert property (
        s_last_bit |=> l_ff.done && l_ff.cnt == 6'(SETUP_BITS))
        else $error("loader not done after last setup bit");
    AST_HOLD_AFTER_DONE: assert property (
        l_ff.done |=> $stable(l_ff.bits) && l_ff.done)
        else $error("setup word changed after load");
    AST_WAIT_FOR_ENABLE: assert property (
        (!first_l && l_ff.phase == LP_IDLE && !chain_enable_in_n_fall)
        |=> l_ff.cnt == 6'h00)
        else $error("bits taken without enable falling");
    AST_REQ_PATTERN: assert property (
        (l_ff.phase == LP_REQ && l_ff.req_cnt < 4'(REQ_BITS))
        |=> l_ff.req_bit == REQ_PATTERN[4'(REQ_BITS-1) -
                                        $past(l_ff.req_cnt)])
        else $error("request bit out of sequence");
endmodule

// ==== hw/rsc_loader.sv ====
// top of the repeater setup chain loader with its register slave
// How it works
// - load from eeprom only in local mode
// - first device drives eeprom chip select high
// - later devices start on enable falling edge
// - exactly forty-eight setup bits are shifted in
// - enable output goes low after last bit
// - enable output feeds next device enable input
// - first device sends nine bit request sequence
// - request pin unused when not first
// - first device makes shared one megahertz clock
// - first drives clock, others follow shared clock
// - reset pin held one millisecond resets core
// - sqe disable input gates aui sqe locally
// - external mode: tp jam input jams port
// - aui jam only in external mode
module rsc_loader
    import rsc_pkg::*;
#(
    parameter logic [15:0] RST_HOLD_CYC = 16'(RST_HOLD_CYC_DEF)
) (
    input wire logic i_clk,
    input wire logic i_rst,
    // ahb-lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // serial setup chain
    input wire logic i_setup_shift_clock,
    output logic o_setup_shift_clock,
    output logic o_setup_shift_clock_oe,
    input wire logic i_chain_enable_in_n,
    output logic o_chain_enable_out_n,
    input wire logic i_setup_bit_in,
    output logic o_eeprom_cs,
    output logic o_load_request,
    output logic o_load_request_oe,
    // straps and control pins
    input wire logic i_mgmt_mode_select,
    input wire logic i_first_position_sel,
    input wire logic i_sqe_disable_in,
    input wire logic i_tp1_jam_sel,
    input wire logic i_tp2_jam_sel,
    input wire logic i_tp3_jam_sel,
    input wire logic i_tp4_jam_sel,
    input wire logic i_aux_port_jam_sel,
    input wire logic i_test_mode,
    input wire logic i_chip_reset,
    output logic o_aui_sqe_off,
    output logic [3:0] o_tp_jam,
    output logic o_aux_port_jam
);
    // =========================================================
    // state
    // =========================================================
    typedef struct packed {
        logic [4:0] div;       // half period counter
        logic sclk;            // shift clock drive level
        logic sclk_oe;         // shift clock drive enable
        logic [15:0] rst_cnt;  // reset pin hold counter
        logic core_rst;        // filtered core reset
        logic run;             // loader running
        logic cs;              // eeprom chip select
        logic req;             // request pin level
        logic req_oe;          // request pin drive enable
        logic chain_enable_out_n_n;          // chain enable out, active low
        logic sqe_off;         // aui sqe disabled
        logic [3:0] tp_jam;    // tp port jam
        logic aux_jam;         // aui port jam
        logic load_en;         // software loader enable
        logic wr_pend;         // write data phase due
        logic [7:0] wr_addr;   // write address, low byte
        logic [31:0] hrdata;   // read data
        logic hreadyout;       // always ready
        logic sclk_seen;       // shared clock level, last cycle
        logic [1:0] warm;      // shared clock edges seen while idle
    } rsc_top_t;
    rsc_top_t r_ff;
    rsc_top_t nxt_r;

    logic [PIN_W-1:0] pin_raw;  // raw pin vector
    logic [PIN_W-1:0] pin_s;    // synchronised pins
    logic [2:0] lk_s;           // synchronised link flags
    logic local_s;
    logic first_s;
    logic chip_s;
    logic done_s;
    logic busy_s;
    logic req_s;
    logic clk_run;              // shift clock generator on
    logic ahb_go;               // valid address phase
    logic load_en_now;          // load enable with write forward
    logic [31:0] rd_word;       // read mux
    logic [31:0] status_w;      // status word
    logic sclk_s;               // shared clock seen in this domain
    logic sclk_rise;            // rising edge of the shared clock

    rsc_link_if lk ();

    // =========================================================
    // pin synchronisers and link crossing
    // =========================================================
    assign pin_raw = {i_chip_reset, i_test_mode, i_aux_port_jam_sel,
                      i_tp4_jam_sel, i_tp3_jam_sel, i_tp2_jam_sel,
                      i_tp1_jam_sel, i_sqe_disable_in,
                      i_first_position_sel, i_mgmt_mode_select};

    rsc_sync #(.W(PIN_W)) u_pin_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d(pin_raw),
        .o_q(pin_s)
    );

    // done and active change once per load, req_bit once per request bit
    rsc_sync #(.W(3)) u_lk_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({lk.req_bit, lk.active, lk.done}),
        .o_q(lk_s)
    );

    assign local_s = pin_s[PIN_MODE];
    assign first_s = pin_s[PIN_FIRST];
    assign chip_s = pin_s[PIN_CHIPRST];
    assign done_s = lk_s[0];
    assign busy_s = lk_s[1];
    assign req_s = lk_s[2];

    // shared clock level, sampled only to count its edges
    rsc_sync #(.W(1)) u_sclk_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d(i_setup_shift_clock),
        .o_q(sclk_s)
    );
    assign sclk_rise = sclk_s & ~r_ff.sclk_seen;

    // strap and run level handed to the shift side
    assign lk.run = r_ff.run;
    assign lk.first = first_s;

    rsc_link_shift u_shift (
        .i_setup_shift_clock(i_setup_shift_clock),
        .i_chain_enable_in_n(i_chain_enable_in_n),
        .i_setup_bit_in(i_setup_bit_in),
        .lk(lk)
    );

    // =========================================================
    // bus decode helpers
    // =========================================================
    assign ahb_go = i_hsel & i_htrans[1] & i_hready;
    // a read right behind a ctrl write sees the new value
    assign load_en_now = (r_ff.wr_pend && r_ff.wr_addr == ADDR_CTRL) ?
                         i_hwdata[CTRL_LOAD_EN] : r_ff.load_en;
    // generator runs only on the first device
    assign clk_run = first_s & local_s & ~r_ff.core_rst;

    // status word
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[ST_DONE] = done_s & r_ff.run;
        status_w[ST_BUSY] = busy_s & r_ff.run;
        status_w[ST_LOCAL] = local_s;
        status_w[ST_FIRST] = first_s;
        status_w[ST_TEST] = pin_s[PIN_TEST];
        status_w[ST_CORE_RST] = r_ff.core_rst;
    end

    // read mux, setup word shown only once loaded
    always_comb begin
        rd_word = 32'h0000_0000;
        unique case (i_haddr[7:0])
            ADDR_CTRL: rd_word[CTRL_LOAD_EN] = load_en_now;
            ADDR_STATUS: rd_word = status_w;
            ADDR_SETUP_LO: begin
                if (status_w[ST_DONE]) begin
                    rd_word = lk.bits[31:0];
                end
            end
            ADDR_SETUP_HI: begin
                if (status_w[ST_DONE]) begin
                    rd_word[15:0] = lk.bits[SETUP_BITS-1:32];
                end
            end
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // =========================================================
    // next state
    // =========================================================
    always_comb begin
        nxt_r = r_ff;
        if (i_rst) begin
            nxt_r = '0;
            nxt_r.chain_enable_out_n_n = 1'b1;
            nxt_r.load_en = 1'b1;
            nxt_r.hreadyout = 1'b1;
        end else begin
            nxt_r.hreadyout = 1'b1;
            // bus write data phase
            if (r_ff.wr_pend && r_ff.wr_addr == ADDR_CTRL) begin
                nxt_r.load_en = i_hwdata[CTRL_LOAD_EN];
            end
            // bus address phase
            nxt_r.wr_pend = ahb_go & i_hwrite;
            if (ahb_go) begin
                nxt_r.wr_addr = i_haddr[7:0];
            end
            if (ahb_go && !i_hwrite) begin
                nxt_r.hrdata = rd_word;
            end
            if (!chip_s) begin
                nxt_r.rst_cnt = 16'h0000;
            end else if (r_ff.rst_cnt != RST_HOLD_CYC) begin
                nxt_r.rst_cnt = r_ff.rst_cnt + 16'h0001;
            end
            nxt_r.core_rst = chip_s && (r_ff.rst_cnt == RST_HOLD_CYC);
            // link side clears itself only while clocked with run
            // low, so run waits for three shared clock edges
            nxt_r.sclk_seen = sclk_s;
            if (r_ff.run) begin
                nxt_r.warm = 2'h0;
            end else if (sclk_rise && !(&r_ff.warm)) begin
                nxt_r.warm = r_ff.warm + 2'h1;
            end
            // load only in local mode, out of reset
            nxt_r.run = r_ff.load_en & local_s & ~r_ff.core_rst &
                        (r_ff.run | (&r_ff.warm));
            if (clk_run) begin
                if (r_ff.div == 5'(SCLK_HALF_CYC - 1)) begin
                    nxt_r.div = 5'h00;
                    nxt_r.sclk = ~r_ff.sclk;
                end else begin
                    nxt_r.div = r_ff.div + 5'h01;
                end
            end else begin
                nxt_r.div = 5'h00;
                nxt_r.sclk = 1'b0;
            end
            // drive clock only in first position
            nxt_r.sclk_oe = first_s & local_s;
            // chip select while this device loads
            nxt_r.cs = first_s & local_s & r_ff.run & ~done_s;
            nxt_r.req = first_s & local_s & r_ff.run & req_s;
            nxt_r.req_oe = first_s & local_s;
            nxt_r.chain_enable_out_n_n = ~(local_s & r_ff.run & done_s);
            nxt_r.sqe_off = local_s & pin_s[PIN_SQE] & ~r_ff.core_rst;
            if (local_s || r_ff.core_rst) begin
                nxt_r.tp_jam = 4'h0;
                nxt_r.aux_jam = 1'b0;
            end else begin
                nxt_r.tp_jam = pin_s[PIN_TP +: 4];
                nxt_r.aux_jam = pin_s[PIN_AUX];
            end
        end
    end

    // registers
    always_ff @(posedge i_clk) begin
        r_ff <= nxt_r;
    end

    // =========================================================
    // outputs, all from flip-flops except the constant o_hresp
    // =========================================================
    assign o_hrdata = r_ff.hrdata;
    assign o_hreadyout = r_ff.hreadyout;
    assign o_hresp = 1'b0;
    assign o_setup_shift_clock = r_ff.sclk;
    assign o_setup_shift_clock_oe = r_ff.sclk_oe;
    assign o_chain_enable_out_n = r_ff.chain_enable_out_n_n;
    assign o_eeprom_cs = r_ff.cs;
    assign o_load_request = r_ff.req;
    assign o_load_request_oe = r_ff.req_oe;
    assign o_aui_sqe_off = r_ff.sqe_off;
    assign o_tp_jam = r_ff.tp_jam;
    assign o_aux_port_jam = r_ff.aux_jam;

    // =========================================================
    // checks
    // =========================================================
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_done_seen;
        local_s && r_ff.run && done_s;
    endsequence
    AST_LOCAL_ONLY: assert property (
        !local_s |=> !r_ff.run)
        else $error("loader runs outside local mode");
    AST_RUN_AFTER_WARM: assert property (
        $rose(r_ff.run) |-> &$past(r_ff.warm))
        else $error("loader started before link side cleared");
    AST_CS_FIRST: assert property (
        r_ff.cs |-> $past(first_s) && $past(local_s) && !$past(done_s))
        else $error("chip select without first position");
    AST_CHAIN_ENABLE_OUT_N_LOW: assert property (
        s_done_seen |=> !o_chain_enable_out_n)
        else $error("enable out not low after load");
    AST_CHAIN_ENABLE_OUT_N_CAUSE: assert property (
        $fell(o_chain_enable_out_n) |-> $past(done_s))
        else $error("enable out fell without load done");
    AST_REQ_UNUSED: assert property (
        !first_s |=> !o_load_request_oe && !o_load_request)
        else $error("request pin used when not first");
    AST_SCLK_TOGGLE: assert property (
        (clk_run && r_ff.div == 5'(SCLK_HALF_CYC - 1))
        |=> r_ff.sclk != $past(r_ff.sclk))
        else $error("shift clock missed its half period");
    AST_SCLK_HOLD: assert property (
        (clk_run && r_ff.div != 5'(SCLK_HALF_CYC - 1))
        |=> $stable(r_ff.sclk))
        else $error("shift clock toggled early");
    AST_RST_HOLD: assert property (
        r_ff.core_rst |-> $past(chip_s) &&
        $past(r_ff.rst_cnt) == RST_HOLD_CYC)
        else $error("core reset before hold time");
    AST_SQE_LOCAL: assert property (
        (local_s && !r_ff.core_rst)
        |=> o_aui_sqe_off == $past(pin_s[PIN_SQE]))
        else $error("sqe gate does not follow input");
    AST_TP_JAM: assert property (
        (!local_s && !r_ff.core_rst)
        |=> o_tp_jam == $past(pin_s[PIN_TP +: 4]))
        else $error("tp jam does not follow select");
    AST_AUX_JAM_EXT: assert property (
        local_s |=> !o_aux_port_jam)
        else $error("aui jam in local mode");
endmodule

// ==== testbench/rsc_eeprom_model.sv ====
// serial eeprom and upstream repeater model for the setup chain
module rsc_eeprom_model (
    input wire logic i_sclk,
    input wire logic i_cs,
    input wire logic i_di,
    input wire logic i_go_n,
    input wire logic [47:0] i_word,
    output logic o_do
);
    timeunit 1ns;
    timeprecision 1ns;
    logic started_ff = 1'b0; // request start bit seen
    logic [3:0] cnt_ff = 4'h0; // edges since start bit
    logic [5:0] idx_ff = 6'h00; // bits already sent
    logic last_ff = 1'b0; // last bit sent
    logic act;
    assign act = ((started_ff && cnt_ff >= 9) || !i_go_n) && idx_ff < 48;
    // idle line shows inverse of last bit
    assign o_do = act ? i_word[47 - idx_ff] : !last_ff;
    // shift out msb first, clear when deselected
    always @(posedge i_sclk) begin
        if (act) begin
            idx_ff <= idx_ff + 6'h01;
            last_ff <= i_word[47 - idx_ff];
        end else if (i_go_n && !i_cs) begin
            idx_ff <= 6'h00;
            started_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end
        if (i_cs && (started_ff || i_di) && cnt_ff < 15) begin
            started_ff <= 1'b1;
            cnt_ff <= cnt_ff + 4'h1;
        end
    end
endmodule

// ==== testbench/testbench.sv ====
// bench for the setup chain loader
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import rsc_pkg::*;
    logic i_clk = 0, i_rst = 1, hsel = 0, hwrite = 0, lclk = 0, lclk_en = 0;
    logic cen_n = 1, crst = 0, mode = 1, first = 1, sqe = 0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rdata, hrdata;
    logic [4:0] jam = 5'h00;
    logic [3:0] tp_jam;
    logic [47:0] word = 48'h9a5c_3e71_c0f5;
    logic hrdy, hresp, so, soe, ceo_n, setup_bit_in, cs, req, roe, sqe_off, aux_jam;
    int bad_count = 0, samples_checked = 0;
    // shared clock wire: design drive or bench link clock
    wire sclk = soe ? so : lclk & lclk_en;
    always #10 i_clk = ~i_clk;
    initial begin #7; forever #40 lclk = ~lclk; end
    rsc_loader #(.RST_HOLD_CYC(16'h0014)) u_rsc_loader (
     .i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
     .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
     .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
     .o_hreadyout(hrdy), .o_hresp(hresp), .i_setup_shift_clock(sclk),
     .o_setup_shift_clock(so), .o_setup_shift_clock_oe(soe),
     .i_chain_enable_in_n(cen_n), .o_chain_enable_out_n(ceo_n),
     .i_setup_bit_in(setup_bit_in), .o_eeprom_cs(cs), .o_load_request(req),
     .o_load_request_oe(roe), .i_mgmt_mode_select(mode),
     .i_first_position_sel(first), .i_sqe_disable_in(sqe),
     .i_tp1_jam_sel(jam[0]), .i_tp2_jam_sel(jam[1]),
     .i_tp3_jam_sel(jam[2]), .i_tp4_jam_sel(jam[3]),
     .i_aux_port_jam_sel(jam[4]), .i_test_mode(1'b0),
     .i_chip_reset(crst), .o_aui_sqe_off(sqe_off),
     .o_tp_jam(tp_jam), .o_aux_port_jam(aux_jam));
    rsc_eeprom_model u_rsc_eeprom_model (.i_sclk(sclk), .i_cs(cs),
     .i_di(req & roe), .i_go_n(cen_n), .i_word(word), .o_do(setup_bit_in));
    // compare one value
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    // wait for hready, bounded
    task automatic hold();
        int n;
        n = 0;
        @(posedge i_clk);
        while (hrdy !== 1'b1 && n < 50) begin n++; @(posedge i_clk); end
        if (n == 50) begin
            bad_count++;
            $display("[FAIL] %0t bus ready timeout", $time);
            end_of_test();
        end
    endtask
    // one ahb-lite single word transfer
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
        hold();
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
        hold();
        rdata = hrdata;
    endtask
    // poll status until load done
    task automatic wait_done();
        int n;
        n = 0;
        ahb(0, ADDR_STATUS, 0);
        while (rdata[ST_DONE] !== 1'b1 && n < 400) begin
            repeat (20) @(posedge i_clk);
            ahb(0, ADDR_STATUS, 0);
            n++;
        end
        if (n == 400) begin
            bad_count++;
            $display("[FAIL] %0t load done timeout", $time);
            end_of_test();
        end
    endtask
    task automatic end_of_test();
        $display("checked %0d bad %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        int n;
        logic p;
        repeat (3) @(posedge i_clk);
        i_rst <= 1'b0;
        wait_done();
        cmp(rdata, 32'h0000_000d);
        ahb(0, ADDR_SETUP_LO, 0);
        cmp(rdata, word[31:0]);
        ahb(0, ADDR_SETUP_HI, 0);
        cmp(rdata, {16'h0, word[47:32]});
        cmp({ceo_n, cs, soe}, 32'h0000_0001);
        ahb(0, 8'h10, 0);
        cmp(rdata, 32'h0000_0000); // unmapped read
        n = 0;
        p = so;
        repeat (1000) begin @(posedge i_clk); n += (so && !p); p = so; end
        cmp(n, 20);
        $display("test first device load done");
        mode <= 1'b0; jam <= 5'h1f; sqe <= 1'b1;
        repeat (8) @(posedge i_clk);
        cmp({aux_jam, tp_jam, sqe_off}, 32'h0000_003e);
        crst <= 1'b1;
        repeat (40) @(posedge i_clk);
        cmp({aux_jam, tp_jam, sqe_off}, 32'h0000_0000);
        crst <= 1'b0; mode <= 1'b1;
        repeat (8) @(posedge i_clk);
        cmp({aux_jam, tp_jam, sqe_off}, 32'h0000_0001);
        jam <= 5'h00; first <= 1'b0; lclk_en <= 1'b1;
        word <= 48'h0123_4c5d_e6f7;
        $display("test pins done");
        ahb(1, ADDR_CTRL, 0);
        repeat (40) @(posedge i_clk);
        ahb(1, ADDR_CTRL, 1);
        repeat (40) @(posedge i_clk);
        ahb(0, ADDR_STATUS, 0);
        cmp({rdata[ST_DONE], soe, roe}, 32'h0000_0000);
        @(negedge lclk);
        @(posedge i_clk);
        cen_n <= 1'b0;
        wait_done();
        ahb(0, ADDR_SETUP_LO, 0);
        cmp(rdata, word[31:0]);
        ahb(0, ADDR_SETUP_HI, 0);
        cmp(rdata, {16'h0, word[47:32]});
        cmp(ceo_n, 32'h0000_0000);
        $display("test chain load done");
        end_of_test();
    end
endmodule
